/* File: verilog/fan_ctrl_pkg.sv */
// Constants and types shared by the fan speed I2C controller files.
package fan_ctrl_pkg;
   localparam int CLK_PERIOD_NS = 8;
   localparam int I2C_QTR_NS    = 250;
   // A quarter of the serial clock period is a least time, so it rounds up.
   localparam int QTR_CYC = (I2C_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [9:0] QTR_LAST = 10'(QTR_CYC - 1);
   localparam logic [3:0] BIT_LAST = 4'h8;

   localparam logic [6:0] CHIP_ADDR    = 7'h48;
   localparam logic [7:0] REG_SPEED    = 8'h00;
   localparam logic [7:0] REG_CONFIG   = 8'h02;
   localparam logic [7:0] CONFIG_VAL   = 8'h0A;
   localparam logic [7:0] REG_FAN0_CNT = 8'h0C;
   localparam logic [7:0] REG_FAN1_CNT = 8'h0E;
   localparam logic [7:0] REG_ALARM    = 8'h12;

   localparam logic [2:0] ADDR_STEP       = 3'h1;
   localparam logic [2:0] REG_STEP        = 3'h2;
   localparam logic [2:0] DATA_STEP       = 3'h3;
   localparam logic [2:0] RD_RESTART_STEP = 3'h3;
   localparam logic [2:0] RD_ADDR_STEP    = 3'h4;
   localparam logic [2:0] RD_DATA_STEP    = 3'h5;
   localparam logic [2:0] WR_LAST_STEP    = 3'h4;
   localparam logic [2:0] RD_LAST_STEP    = 3'h6;

   localparam int RPM_LOW        = 2000;
   localparam int RPM_HIGH       = 5000;
   localparam int PULSES_PER_REV = 2;
   localparam int COUNT_GATE_MS  = 1000;
   localparam int MS_PER_MIN     = 60000;
   localparam int RPM_PER_COUNT  = MS_PER_MIN / (PULSES_PER_REV * COUNT_GATE_MS);
   localparam logic [12:0] SPEED_SET_LOW  = 13'(RPM_LOW);
   localparam logic [12:0] SPEED_SET_HIGH = 13'(RPM_HIGH);

   localparam int GENERAL_PIN_ALARM_BIT            = 3;
   localparam int SPEED_COUNTER_OVERFLOW_ALARM_BIT = 2;
   localparam int DRIVE_MIN_ALARM_BIT              = 1;
   localparam int DRIVE_TOP_ALARM_BIT              = 0;
   localparam int ALARM_MSB                        = 3;

   localparam int IN_SEL = 0;
   localparam int IN_BTN = 1;
   localparam logic [1:0] IN_RST = 2'h2;

   typedef enum logic [1:0] {CMD_START, CMD_WRITE, CMD_READ, CMD_STOP} i2c_cmd_e;
   typedef enum logic [2:0] {T_CFG, T_SPEED, T_RD0, T_RD1, T_ALM} txn_e;

   // Tachometer count that the chip must see in one gate period at this speed.
   function automatic logic [7:0] rpm_to_count(input int rpm);
      return 8'(rpm * PULSES_PER_REV * COUNT_GATE_MS / MS_PER_MIN);
   endfunction : rpm_to_count
endpackage : fan_ctrl_pkg

/* File: verilog/i2c_byte_engine.sv */
// Two-wire bus engine: start, stop, and one byte written or read per command.
`timescale 1ns/1ns
module i2c_byte_engine
   import fan_ctrl_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       cmd_valid_i,
   input  wire i2c_cmd_e   cmd_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       sda_i,
   output logic            scl_o,
   output logic            scl_oe_n_o,
   output logic            sda_o,
   output logic            sda_oe_n_o,
   output logic            done_o,
   output logic            nack_o,
   output logic [7:0]      rdata_o
);
   typedef enum logic [1:0] {E_IDLE, E_START, E_BIT, E_STOP} eng_st_e;

   eng_st_e    st, next_st;
   logic [1:0] ph, next_ph;
   logic [9:0] qcnt, next_qcnt;
   logic [3:0] bitn, next_bitn;
   logic [7:0] shreg, next_shreg;
   logic       rd, next_rd;
   logic       scl_oe_n, next_scl_oe_n;
   logic       sda_oe_n, next_sda_oe_n;
   logic       nack, next_nack;
   logic       done, next_done;
   logic [2:0] sda_sync;
   logic       sda_f, next_sda_f;
   logic       pin_lvl;
   logic       tick;
   logic       fin;

   assign tick = (qcnt == QTR_LAST);

   always_comb begin
      next_st       = st;
      next_ph       = ph;
      next_qcnt     = qcnt;
      next_bitn     = bitn;
      next_shreg    = shreg;
      next_rd       = rd;
      next_scl_oe_n = scl_oe_n;
      next_sda_oe_n = sda_oe_n;
      next_nack     = nack;
      next_done     = 1'b0;
      fin           = 1'b0;
      next_sda_f    = (sda_sync[1] == sda_sync[2]) ? sda_sync[1] : sda_f;
      if (st == E_IDLE) begin
         next_qcnt = '0;
         next_ph   = '0;
         if (cmd_valid_i) begin
            next_bitn  = '0;
            next_shreg = wdata_i;
            next_rd    = (cmd_i == CMD_READ);
            case (cmd_i)
               CMD_START: next_st = E_START;
               CMD_STOP:  next_st = E_STOP;
               default:   next_st = E_BIT;
            endcase
         end
      end else if (tick) begin
         next_qcnt = '0;
         next_ph   = ph + 2'h1;
         case (st)
            E_BIT: begin
               case (ph)
                  2'h0: next_sda_oe_n = (bitn == BIT_LAST) || rd || shreg[7];
                  2'h1: next_scl_oe_n = 1'b1;
                  2'h2: begin
                     if (bitn == BIT_LAST) begin
                        next_nack = sda_f;
                     end else begin
                        next_shreg = {shreg[6:0], sda_f};
                     end
                  end
                  default: begin
                     next_scl_oe_n = 1'b0;
                     next_bitn     = bitn + 4'h1;
                     fin           = (bitn == BIT_LAST);
                  end
               endcase
            end
            default: begin
               // Start and stop share one pattern with the data line edges swapped; only a start pulls the clock low at the end.
               case (ph)
                  2'h0: next_sda_oe_n = (st == E_START);
                  2'h1: next_scl_oe_n = 1'b1;
                  2'h2: next_sda_oe_n = (st != E_START);
                  default: begin
                     next_scl_oe_n = (st != E_START);
                     fin           = 1'b1;
                  end
               endcase
            end
         endcase
      end else begin
         next_qcnt = qcnt + 10'h1;
      end
      if (fin) begin
         next_st   = E_IDLE;
         next_done = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st       <= E_IDLE;
         ph       <= '0;
         qcnt     <= '0;
         bitn     <= '0;
         shreg    <= '0;
         rd       <= 1'b0;
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
         nack     <= 1'b0;
         done     <= 1'b0;
         sda_sync <= 3'h7;
         sda_f    <= 1'b1;
         pin_lvl  <= 1'b0;
      end else begin
         st       <= next_st;
         ph       <= next_ph;
         qcnt     <= next_qcnt;
         bitn     <= next_bitn;
         shreg    <= next_shreg;
         rd       <= next_rd;
         scl_oe_n <= next_scl_oe_n;
         sda_oe_n <= next_sda_oe_n;
         nack     <= next_nack;
         done     <= next_done;
         sda_sync <= {sda_sync[1:0], sda_i};
         sda_f    <= next_sda_f;
         pin_lvl  <= 1'b0;
      end
   end

   assign scl_o      = pin_lvl;
   assign sda_o      = pin_lvl;
   assign scl_oe_n_o = scl_oe_n;
   assign sda_oe_n_o = sda_oe_n;
   assign done_o     = done;
   assign nack_o     = nack;
   assign rdata_o    = shreg;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_scl_on_tick;
      $changed(scl_oe_n) |-> $past(tick);
   endproperty
   a_scl_on_tick: assert property (p_scl_on_tick)
      else $error("serial clock moved off a prescaler tick");
   property p_sda_stable_high;
      (st == E_BIT && scl_oe_n && $past(scl_oe_n)) |-> $stable(sda_oe_n);
   endproperty
   a_sda_stable_high: assert property (p_sda_stable_high)
      else $error("data moved while clock high in a bit");
   property p_done_single;
      done |=> !done;
   endproperty
   a_done_single: assert property (p_done_single)
      else $error("done held longer than one cycle");
endmodule : i2c_byte_engine

/* File: verilog/fan_speed_i2c_controller.sv */
// Top level: configures the fan chip, sets the target speed and polls speeds and alarms.
`timescale 1ns/1ns
module fan_speed_i2c_controller
   import fan_ctrl_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        speed_sel_i,
   input  wire logic        clear_btn_n_i,
   input  wire logic        sda_i,
   output logic             scl_o,
   output logic             scl_oe_n_o,
   output logic             sda_o,
   output logic             sda_oe_n_o,
   output logic [3:0]       led_o,
   output logic [12:0]      speed_set_o,
   output logic [13:0]      fan0_speed_o,
   output logic [13:0]      fan1_speed_o,
   output logic             config_done_o,
   output logic             ack_error_o
);
   typedef enum logic {M_ISSUE, M_WAIT} main_st_e;

   main_st_e    mst, next_mst;
   txn_e        txn, next_txn;
   logic [2:0]  step, next_step;
   logic        cmd_valid, next_cmd_valid;
   i2c_cmd_e    cmd, next_cmd;
   logic [7:0]  cmd_data, next_cmd_data;
   logic        cfg_done, next_cfg_done;
   logic        sw_written, next_sw_written;
   logic        txn_fail, next_txn_fail;
   logic        ack_err, next_ack_err;
   logic [12:0] speed_set, next_speed_set;
   logic [13:0] fan0, next_fan0;
   logic [13:0] fan1, next_fan1;
   logic [3:0]  led, next_led;
   logic [3:0]  alm_set;
   logic [1:0]  in_s1, in_s2, in_s3;
   logic [1:0]  in_f, next_in_f;
   logic        sel;
   logic        pressed;
   logic        eng_done;
   logic        eng_nack;
   logic [7:0]  eng_rdata;

   function automatic logic is_rd(input txn_e t);
      return (t == T_RD0) || (t == T_RD1) || (t == T_ALM);
   endfunction : is_rd

   function automatic logic [2:0] last_of(input txn_e t);
      return is_rd(t) ? RD_LAST_STEP : WR_LAST_STEP;
   endfunction : last_of

   function automatic i2c_cmd_e cmd_of(input txn_e t, input logic [2:0] s);
      if (s == 3'h0 || (is_rd(t) && s == RD_RESTART_STEP)) return CMD_START;
      if (s == last_of(t)) return CMD_STOP;
      if (is_rd(t) && s == RD_DATA_STEP) return CMD_READ;
      return CMD_WRITE;
   endfunction : cmd_of

   function automatic logic [7:0] reg_of(input txn_e t);
      case (t)
         T_CFG:   return REG_CONFIG;
         T_SPEED: return REG_SPEED;
         T_RD0:   return REG_FAN0_CNT;
         T_RD1:   return REG_FAN1_CNT;
         default: return REG_ALARM;
      endcase
   endfunction : reg_of

   function automatic logic [7:0] byte_of(input txn_e t, input logic [2:0] s, input logic hi);
      if (s == ADDR_STEP) return {CHIP_ADDR, 1'b0};
      if (s == RD_ADDR_STEP) return {CHIP_ADDR, 1'b1};
      if (s == REG_STEP) return reg_of(t);
      if (t == T_CFG) return CONFIG_VAL;
      return hi ? rpm_to_count(RPM_HIGH) : rpm_to_count(RPM_LOW);
   endfunction : byte_of

   function automatic logic [13:0] count_to_rpm(input logic [7:0] c);
      return 14'(int'(c) * RPM_PER_COUNT);
   endfunction : count_to_rpm

   i2c_byte_engine u_engine (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .cmd_valid_i (cmd_valid),
      .cmd_i       (cmd),
      .wdata_i     (cmd_data),
      .sda_i       (sda_i),
      .scl_o       (scl_o),
      .scl_oe_n_o  (scl_oe_n_o),
      .sda_o       (sda_o),
      .sda_oe_n_o  (sda_oe_n_o),
      .done_o      (eng_done),
      .nack_o      (eng_nack),
      .rdata_o     (eng_rdata)
   );

   // A pin level counts once the second and third stages agree.
   assign next_in_f = (in_s2 & in_s3) | (in_f & (in_s2 ^ in_s3));
   assign sel       = in_f[IN_SEL];
   assign pressed   = !in_f[IN_BTN];

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         in_s1 <= IN_RST;
         in_s2 <= IN_RST;
         in_s3 <= IN_RST;
         in_f  <= IN_RST;
      end else begin
         in_s1 <= {clear_btn_n_i, speed_sel_i};
         in_s2 <= in_s1;
         in_s3 <= in_s2;
         in_f  <= next_in_f;
      end
   end

   always_comb begin
      next_mst        = mst;
      next_txn        = txn;
      next_step       = step;
      next_cmd_valid  = 1'b0;
      next_cmd        = cmd;
      next_cmd_data   = cmd_data;
      next_cfg_done   = cfg_done;
      next_sw_written = sw_written;
      next_txn_fail   = txn_fail;
      next_ack_err    = ack_err;
      next_speed_set  = speed_set;
      next_fan0       = fan0;
      next_fan1       = fan1;
      alm_set         = 4'h0;
      case (mst)
         M_ISSUE: begin
            next_cmd_valid = 1'b1;
            next_cmd       = cmd_of(txn, step);
            next_cmd_data  = byte_of(txn, step, sel);
            if (txn == T_SPEED && step == DATA_STEP) begin
               next_sw_written = sel;
               next_speed_set  = sel ? SPEED_SET_HIGH : SPEED_SET_LOW;
            end
            next_mst = M_WAIT;
         end
         default: begin
            if (eng_done) begin
               next_mst  = M_ISSUE;
               next_step = step + 3'h1;
               // A byte the chip did not acknowledge ends the transfer early.
               if (cmd == CMD_WRITE && eng_nack) begin
                  next_txn_fail = 1'b1;
                  next_step     = last_of(txn);
               end
               if (cmd == CMD_READ) begin
                  if (txn == T_RD0) begin
                     next_fan0 = count_to_rpm(eng_rdata);
                  end
                  if (txn == T_RD1) begin
                     next_fan1 = count_to_rpm(eng_rdata);
                  end
                  if (txn == T_ALM) begin
                     alm_set = eng_rdata[ALARM_MSB:0];
                  end
               end
               if (step == last_of(txn)) begin
                  next_step     = 3'h0;
                  next_txn_fail = 1'b0;
                  next_ack_err  = txn_fail;
                  // A failed transfer is retried before the sequence moves on.
                  if (!txn_fail) begin
                     case (txn)
                        T_CFG:   next_txn = T_SPEED;
                        T_SPEED: begin
                           next_cfg_done = 1'b1;
                           next_txn      = T_RD0;
                        end
                        T_RD0:   next_txn = T_RD1;
                        T_RD1:   next_txn = T_ALM;
                        default: next_txn = (sel != sw_written) ? T_SPEED : T_RD0;
                     endcase
                  end
               end
            end
         end
      endcase
      // A new alarm wins over a clear that arrives in the same cycle.
      next_led = (pressed ? 4'h0 : led) | alm_set;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mst        <= M_ISSUE;
         txn        <= T_CFG;
         step       <= '0;
         cmd_valid  <= 1'b0;
         cmd        <= CMD_START;
         cmd_data   <= '0;
         cfg_done   <= 1'b0;
         sw_written <= 1'b0;
         txn_fail   <= 1'b0;
         ack_err    <= 1'b0;
         speed_set  <= '0;
         fan0       <= '0;
         fan1       <= '0;
         led        <= '0;
      end else begin
         mst        <= next_mst;
         txn        <= next_txn;
         step       <= next_step;
         cmd_valid  <= next_cmd_valid;
         cmd        <= next_cmd;
         cmd_data   <= next_cmd_data;
         cfg_done   <= next_cfg_done;
         sw_written <= next_sw_written;
         txn_fail   <= next_txn_fail;
         ack_err    <= next_ack_err;
         speed_set  <= next_speed_set;
         fan0       <= next_fan0;
         fan1       <= next_fan1;
         led        <= next_led;
      end
   end

   assign led_o         = led;
   assign speed_set_o   = speed_set;
   assign fan0_speed_o  = fan0;
   assign fan1_speed_o  = fan1;
   assign config_done_o = cfg_done;
   assign ack_error_o   = ack_err;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_cfg_first;
      (cmd_valid && is_rd(txn)) |-> cfg_done;
   endproperty
   a_cfg_first: assert property (p_cfg_first)
      else $error("polling started before configuration");
   property p_speed_low;
      (cmd_valid && txn == T_SPEED && step == DATA_STEP && !sw_written)
         |-> (cmd_data == rpm_to_count(RPM_LOW) && speed_set == SPEED_SET_LOW);
   endproperty
   a_speed_low: assert property (p_speed_low)
      else $error("low speed target written wrong");
   property p_speed_high;
      (cmd_valid && txn == T_SPEED && step == DATA_STEP && sw_written)
         |-> (cmd_data == rpm_to_count(RPM_HIGH) && speed_set == SPEED_SET_HIGH);
   endproperty
   a_speed_high: assert property (p_speed_high)
      else $error("high speed target written wrong");
   property p_fan0_src;
      $changed(fan0) |-> $past(eng_done && txn == T_RD0 && cmd == CMD_READ);
   endproperty
   a_fan0_src: assert property (p_fan0_src)
      else $error("fan zero speed changed without its read");
   property p_alarm_src;
      ((led & ~$past(led)) != 4'h0) |-> $past(eng_done && txn == T_ALM);
   endproperty
   a_alarm_src: assert property (p_alarm_src)
      else $error("LED raised without an alarm status read");
   property p_led_hold;
      !pressed |=> ((led & $past(led)) == $past(led));
   endproperty
   a_led_hold: assert property (p_led_hold)
      else $error("alarm LED dropped without the button");
   property p_led_clear;
      (pressed && alm_set == 4'h0) |=> (led == 4'h0);
   endproperty
   a_led_clear: assert property (p_led_clear)
      else $error("button did not clear the LEDs");
   property p_pin_alarm;
      alm_set[GENERAL_PIN_ALARM_BIT] |=> led_o[GENERAL_PIN_ALARM_BIT];
   endproperty
   a_pin_alarm: assert property (p_pin_alarm)
      else $error("pin alarm not shown on LED 3");
   property p_overflow_alarm;
      alm_set[SPEED_COUNTER_OVERFLOW_ALARM_BIT] |=> led_o[SPEED_COUNTER_OVERFLOW_ALARM_BIT];
   endproperty
   a_overflow_alarm: assert property (p_overflow_alarm)
      else $error("overflow alarm not shown on LED 2");
   property p_min_alarm;
      alm_set[DRIVE_MIN_ALARM_BIT] |=> led_o[DRIVE_MIN_ALARM_BIT];
   endproperty
   a_min_alarm: assert property (p_min_alarm)
      else $error("minimum drive alarm not shown on LED 1");
   property p_top_alarm;
      alm_set[DRIVE_TOP_ALARM_BIT] |=> led_o[DRIVE_TOP_ALARM_BIT];
   endproperty
   a_top_alarm: assert property (p_top_alarm)
      else $error("maximum drive alarm not shown on LED 0");
   property p_upper_ignored;
      (eng_done && txn == T_ALM && cmd == CMD_READ && eng_rdata[3:0] == 4'h0 && !pressed)
         |=> (led == $past(led));
   endproperty
   a_upper_ignored: assert property (p_upper_ignored)
      else $error("upper status bits changed the LEDs");
endmodule : fan_speed_i2c_controller

/* File: verification/fan_chip_model.sv */
// Behavioural fan chip on the two-wire bus: acknowledge, register writes and read data.
`timescale 1ns/1ns
module fan_chip_model
   import fan_ctrl_pkg::*;
(
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   input  wire logic [7:0] fan0_cnt_i,
   input  wire logic [7:0] fan1_cnt_i,
   input  wire logic [7:0] alarm_i,
   input  wire logic       refuse_i,
   output logic            pull_o,
   output logic [7:0]      speed_cnt_o,
   output logic [7:0]      config_o,
   output logic [7:0]      first_reg_o
);
   int         idx  = -1;
   int         bits = 0;
   logic       rd   = 1'b0;
   logic       hit  = 1'b0;
   logic [7:0] sh   = 8'h00;
   logic [7:0] tx   = 8'h00;
   logic [7:0] ptr  = 8'h00;
   initial begin
      pull_o = 1'b0;
      speed_cnt_o = 8'h00;
      config_o = 8'h00;
      first_reg_o = 8'hFF;
   end
   always @(negedge sda_i) if (scl_i) begin
      idx = 0;
      bits = 0;
      rd = 1'b0;
      hit = 1'b0;
   end
   always @(posedge sda_i) if (scl_i) idx = -1;
   always @(posedge scl_i) begin
      if (idx >= 0 && bits < 8) begin
         sh = {sh[6:0], sda_i};
         bits++;
      end else if (idx >= 0) begin
         bits = 0;
         // A not-acknowledge from the master ends the read, so the line is released.
         if (rd && sda_i) begin
            rd = 1'b0;
            hit = 1'b0;
         end
      end
   end
   always @(negedge scl_i) begin
      pull_o = 1'b0;
      if (idx >= 0 && bits == 8 && !rd) begin
         if (idx == 0) begin
            // A refused address is left unacknowledged and the chip stays deaf until a start.
            hit = (sh[7:1] == CHIP_ADDR) && !refuse_i;
            rd = hit & sh[0];
            tx = (ptr == REG_FAN0_CNT) ? fan0_cnt_i : (ptr == REG_FAN1_CNT) ? fan1_cnt_i :
                 (ptr == REG_ALARM) ? alarm_i : 8'h00;
         end else if (idx == 1 && hit) begin
            ptr = sh;
         end else if (hit) begin
            if (ptr == REG_SPEED) speed_cnt_o = sh;
            if (ptr == REG_CONFIG) config_o = sh;
            if (first_reg_o == 8'hFF) first_reg_o = ptr;
         end
         pull_o = hit;
         idx++;
      end else if (rd && bits < 8) begin
         pull_o = ~tx[7 - bits];
      end
   end
endmodule : fan_chip_model

/* File: verification/tb_top.sv */
// Self-checking bench: fan speed controller against the behavioural fan chip.
`timescale 1ns/1ns
module tb_top
   import fan_ctrl_pkg::*;
();
   logic        clk         = 1'b0;
   logic        rst_n       = 1'b0;
   logic        speed_sel   = 1'b0;
   logic        clear_btn_n = 1'b1;
   logic [7:0]  alarm       = 8'hF6;
   logic        refuse      = 1'b0;
   logic        scl_o, scl_oe_n, sda_o, sda_oe_n, pull, config_done, ack_error;
   logic [3:0]  led;
   logic [12:0] speed_set;
   logic [13:0] fan0_speed, fan1_speed;
   logic [7:0]  speed_cnt, config_val, first_reg;
   int          err_count       = 0;
   int          samples_checked = 0;
   wire         scl = scl_oe_n ? 1'b1 : scl_o;
   wire         sda = (sda_oe_n ? 1'b1 : sda_o) & ~pull;

   fan_speed_i2c_controller u_fan_speed_i2c_controller (
      .core_clk_i(clk), .rst_n_i(rst_n), .speed_sel_i(speed_sel),
      .clear_btn_n_i(clear_btn_n), .sda_i(sda), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n),
      .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .led_o(led), .speed_set_o(speed_set),
      .fan0_speed_o(fan0_speed), .fan1_speed_o(fan1_speed),
      .config_done_o(config_done), .ack_error_o(ack_error));
   // Fan counts 72 and 68 read back as 2160 and 2040 revolutions per minute.
   fan_chip_model u_fan_chip_model (
      .scl_i(scl), .sda_i(sda), .fan0_cnt_i(8'h48), .fan1_cnt_i(8'h44), .alarm_i(alarm),
      .refuse_i(refuse),
      .pull_o(pull), .speed_cnt_o(speed_cnt), .config_o(config_val), .first_reg_o(first_reg));

   initial begin
      forever #4 clk = ~clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic finish_test();
      $display("checks=%0d errors=%0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test

   // Waits for configuration done (0), any lit alarm (1), the high speed target (2),
   // all four alarms (3), an acknowledge error (4) or its recovery (5).
   task automatic wait_for(input int sel);
      int n;
      for (n = 0; n < 25000; n++) begin
         @(negedge clk);
         if ((sel == 0 && config_done === 1'b1) || (sel == 1 && led !== 4'h0) ||
             (sel == 2 && speed_set === SPEED_SET_HIGH) || (sel == 3 && led === 4'hF) ||
             (sel == 4 && ack_error === 1'b1) || (sel == 5 && ack_error === 1'b0)) break;
      end
      if (n == 25000) begin
         err_count++;
         finish_test();
      end
   endtask : wait_for

   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk(16'(led), 16'h0000);
      chk(16'({config_done, scl_oe_n, sda_oe_n}), 16'h0003);
      chk(16'({scl_o, sda_o}), 16'h0000);
      wait_for(0);
      chk(16'(first_reg), 16'(REG_CONFIG));
      chk(16'(config_val), 16'(CONFIG_VAL));
      // Two pulses a turn over a one second gate: 2000 gives 66, 5000 gives 166.
      chk(16'(speed_cnt), 16'h0042);
      chk(16'(speed_set), 16'(SPEED_SET_LOW));
      chk(16'(ack_error), 16'h0000);
      wait_for(1);
      chk(16'(led), 16'h0006);
      chk(16'(fan0_speed), 16'h0870);
      chk(16'(fan1_speed), 16'h07F8);
      @(posedge clk);
      alarm <= 8'h09;
      speed_sel <= 1'b1;
      wait_for(2);
      chk(16'(config_done), 16'h0001);
      // The new alarm value is only seen by the alarm read after the speed rewrite.
      wait_for(3);
      chk(16'(led), 16'h000F);
      chk(16'(speed_cnt), 16'h00A6);
      @(posedge clk);
      alarm <= 8'hF0;
      clear_btn_n <= 1'b0;
      repeat (8) @(posedge clk);
      clear_btn_n <= 1'b1;
      @(negedge clk);
      chk(16'(led), 16'h0000);
      @(posedge clk);
      refuse <= 1'b1;
      wait_for(4);
      chk(16'(ack_error), 16'h0001);
      @(posedge clk);
      refuse <= 1'b0;
      wait_for(5);
      chk(16'({ack_error, config_done}), 16'h0001);
      chk(16'(fan0_speed), 16'h0870);
      // Long enough for the rest of the poll, so an alarm read with only upper bits set is seen.
      repeat (12000) @(posedge clk);
      @(negedge clk);
      chk(16'(led), 16'h0000);
      @(posedge clk);
      rst_n <= 1'b0;
      @(negedge clk);
      chk(16'({config_done, scl_oe_n, sda_oe_n}), 16'h0003);
      chk(16'(speed_set), 16'h0000);
      finish_test();
   end
endmodule : tb_top
